// >>> inc/awsc_consts.svh
`ifndef AWSC_CONSTS_SVH
`define AWSC_CONSTS_SVH

// Register indices; byte address is four times the index
`define AWSC_IDX_INACT        6'h29
`define AWSC_IDX_CTRL_ONE     6'h2A
`define AWSC_IDX_CTRL_TWO     6'h2B
`define AWSC_IDX_WAKE_CFG     6'h2C
`define AWSC_IDX_INT_CFG      6'h2D
`define AWSC_IDX_STATUS       6'h30
`define AWSC_IDX_MASK         6'h31
`define AWSC_IDX_STATE        6'h32

// Reset values
`define AWSC_RST_BYTE         8'h00

// system_control_one fields
`define AWSC_SLEEP_RATE_LSB   6
`define AWSC_WAKE_RATE_LSB    3
`define AWSC_ACTIVE_BIT       0

// system_control_two fields
`define AWSC_SOFT_RST_BIT     6
`define AWSC_AUTO_SLEEP_BIT   2

// wake_source_config fields: gate bit, then wake selects for sources 1..4
`define AWSC_FIFO_GATE_BIT    7
`define AWSC_WAKE_SEL_LSB     3

// interrupt_enable_config fields: transition enable, source enables 0..4
`define AWSC_SW_INT_BIT       7
`define AWSC_INT_SRC_LSB      2

// Status / mask bits
`define AWSC_ST_TRANSITION    0
`define AWSC_ST_REFUSED       1

// Source vector: 0 FIFO gate, 1 freefall/motion, 2 tap, 3 orientation, 4 transient
`define AWSC_NUM_SRC          5

// Timing
`define AWSC_CLK_PERIOD_NS    10
`define AWSC_BASE_PERIOD_NS   1250000
`define AWSC_STEP_NS          320000000
`define AWSC_STEP_SLOW_NS     640000000
`define AWSC_BASE_CYCLES      (`AWSC_BASE_PERIOD_NS / `AWSC_CLK_PERIOD_NS)
`define AWSC_STEP_BASE_TICKS  (`AWSC_STEP_NS / `AWSC_BASE_PERIOD_NS)
`define AWSC_SLOW_BASE_TICKS  (`AWSC_STEP_SLOW_NS / `AWSC_BASE_PERIOD_NS)

// Log2 of base ticks per sample for rate codes 0..7, one nibble per code
`define AWSC_RATE_SHIFTS      32'h9764_3210
`define AWSC_SLOWEST_SHIFT    4'h9

`endif

// >>> inc/awsc_pkg.sv
package awsc_pkg;

  // Operating mode of the sequencer
  typedef enum logic [1:0] {
    AWSC_STANDBY = 2'b00,
    AWSC_WAKE    = 2'b01,
    AWSC_SLEEP   = 2'b10
  } awsc_mode_type;

  // Whole state of the controller
  typedef struct packed {
    awsc_mode_type mode;
    logic [7:0]    inact_dur;
    logic [7:0]    ctrl_one;
    logic [7:0]    ctrl_two;
    logic [7:0]    wake_cfg;
    logic [7:0]    int_cfg;
    logic [1:0]    status;
    logic [1:0]    mask;
    logic [8:0]    sub_cnt;
    logic [7:0]    step_cnt;
    logic          hold;
    logic [2:0]    rate;
    logic          ack;
    logic [7:0]    rdata;
  } awsc_state_type;

  // State of the sample-rate divider
  typedef struct packed {
    logic [16:0] cyc;
    logic [8:0]  base;
    logic        tick;
  } awsc_tick_type;

endpackage

// >>> core/awsc_evt_src.sv
`timescale 1ns/1ps
module awsc_evt_src
  import awsc_pkg::*;
#(
  parameter bit CAN_WAKE = 1'b1
) (
  // Event and its configuration
  input  wire logic evt,
  input  wire logic int_en,
  input  wire logic wake_sel,
  // Qualified effects
  output logic      restart,
  output logic      wake
);

  // Any enabled source restarts the idle timer
  assign restart = evt & int_en;
  // Waking also needs the wake select; a gate-only source never wakes
  assign wake = CAN_WAKE & evt & int_en & wake_sel;

endmodule

// >>> core/awsc_rate_tick.sv
`timescale 1ns/1ps
`include "awsc_consts.svh"
module awsc_rate_tick
  import awsc_pkg::*;
#(
  parameter int BASE_CYCLES = `AWSC_BASE_CYCLES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       soft_clr,
  // Selected rate code
  input  wire logic [2:0] rate_code,
  // One-cycle pulse per sample
  output logic            odr_tick
);

  awsc_tick_type t_q;  // Registered divider state
  awsc_tick_type t_d;  // Next divider state

  logic [3:0] shift;   // Base ticks per sample, log2
  logic [8:0] phase;   // Base counter bits that must be zero
  logic       base_hit;

  // Rate code picks how many base ticks make one sample
  always_comb begin
    t_d      = t_q;
    shift    = 4'(`AWSC_RATE_SHIFTS >> {rate_code, 2'b00});
    phase    = 9'h1FF >> (4'h9 - shift);
    base_hit = (t_q.cyc == 17'(BASE_CYCLES - 1));
    t_d.tick = 1'b0;
    if (base_hit) begin
      t_d.cyc  = '0;
      t_d.base = t_q.base + 9'h001;
      // Sample edge when the low bits of the base count wrap
      t_d.tick = ((t_q.base & phase) == 9'h000);
    end else begin
      t_d.cyc = t_q.cyc + 17'h0_0001;
    end
    if (soft_clr) begin
      t_d = '0;
    end
  end

  // Divider registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  assign odr_tick = t_q.tick;

endmodule

// >>> core/awsc_top.sv
// Summary of operation
// - Auto sleep drops to sleep rate after idle
// - Idle duration: 8-bit RW register, resets zero
// - Idle step 320 ms, 640 ms at slowest
// - FIFO gate and motion events restart timer
// - Only motion events wake; FIFO never wakes
// - Transition and sample-ready events change nothing
// - Gate holds FIFO across rate change until flush
// - Functions keep running at sleep rate asleep
// - Auto sleep off: only standby and wake
// - Enabled transition interrupt on every sleep change
// - Sleep rate field picks four sleep rates
// - Sleep rate overrides rate for whole system
// - Wake rate field picks eight wake rates
// - Auto sleep enable bit defaults off
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`include "awsc_consts.svh"
module awsc_top
  import awsc_pkg::*;
#(
  parameter int BASE_CYCLES = `AWSC_BASE_CYCLES
) (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  // Avalon-MM register slave
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Detection events, one-cycle pulses
  input  wire logic        EVT_TRANSIENT,
  input  wire logic        EVT_ORIENTATION,
  input  wire logic        EVT_TAP,
  input  wire logic        EVT_FREEFALL_MOTION,
  input  wire logic        EVT_FIFO_GATE,
  // Sample FIFO gating
  input  wire logic        SAMPLE_VALID,
  input  wire logic        FIFO_FLUSH,
  output logic             SAMPLE_WRITE,
  output logic             FIFO_HOLD,
  // Rate and mode
  output logic             SAMPLE_TICK,
  output logic [2:0]       RATE_CODE,
  output logic [1:0]       MODE,
  // Interrupt
  output logic             IRQ
);

  // One image serves both the pin reset and the software reset, so the
  // two can never disagree about a default
  localparam awsc_state_type S_RST = '0;  // All fields zero, standby

  awsc_state_type s_q;  // Registered state
  awsc_state_type s_d;  // Next state

  logic [`AWSC_NUM_SRC-1:0] src_evt;      // Raw event vector
  logic [`AWSC_NUM_SRC-1:0] src_int_en;   // Per-source enables
  logic [`AWSC_NUM_SRC-1:0] src_wake_sel; // Per-source wake selects
  logic [`AWSC_NUM_SRC-1:0] src_restart;  // Qualified restarts
  logic [`AWSC_NUM_SRC-1:0] src_wake;     // Qualified wakes
  logic                     odr_tick;     // Sample tick at current rate
  logic                     req;          // Bus request present
  logic                     accept;       // Bus request completes now
  logic [5:0]               idx;          // Word index of the access
  logic                     soft_clr;     // Software reset this edge
  logic                     transition;   // Sleep entry or exit
  logic                     auto_on;      // Auto sleep enabled
  logic                     active;       // Active bit
  logic [3:0]               wake_shift;   // Log2 base ticks per sample
  logic [9:0]               per_step;     // Samples per idle step
  logic [7:0]               rd_mux;       // Read data selection

  // Source vector, order fixed by the field layout
  // Index 0 is FIFO activity, which may restart the timer but never wake
  assign src_evt      = {EVT_TRANSIENT, EVT_ORIENTATION, EVT_TAP,
                         EVT_FREEFALL_MOTION, EVT_FIFO_GATE};
  assign src_int_en   = s_q.int_cfg[`AWSC_INT_SRC_LSB +: `AWSC_NUM_SRC];
  assign src_wake_sel = {s_q.wake_cfg[`AWSC_WAKE_SEL_LSB +: 4], 1'b0};

  // One qualifier per source; only the FIFO gate cannot wake
  genvar g;
  generate
    for (g = 0; g < `AWSC_NUM_SRC; g++) begin : g_src
      awsc_evt_src #(
        .CAN_WAKE (g != 0)
      ) u_src (
        .evt      (src_evt[g]),
        .int_en   (src_int_en[g]),
        .wake_sel (src_wake_sel[g]),
        .restart  (src_restart[g]),
        .wake     (src_wake[g])
      );
    end
  endgenerate

  // Sample tick generator follows the effective rate code
  // A rate change does not restart the divider, so the first tick may come early
  awsc_rate_tick #(
    .BASE_CYCLES (BASE_CYCLES)
  ) u_tick (
    .clk       (CORE_CLK),
    .rst_n     (RST_N),
    .soft_clr  (soft_clr),
    .rate_code (s_q.rate),
    .odr_tick  (odr_tick)
  );

  // Bus decode; one wait state on every access
  // The wait cycle lets read data come from a flop instead of the mux,
  // at the cost of one extra cycle per register access
  assign req      = AVS_READ | AVS_WRITE;
  assign accept   = req & s_q.ack;
  assign idx      = AVS_ADDRESS[7:2];
  assign soft_clr = accept & AVS_WRITE & AVS_BYTEENABLE[0] &
                    (idx == `AWSC_IDX_CTRL_TWO) &
                    AVS_WRITEDATA[`AWSC_SOFT_RST_BIT];
  assign auto_on  = s_q.ctrl_two[`AWSC_AUTO_SLEEP_BIT];
  assign active   = s_q.ctrl_one[`AWSC_ACTIVE_BIT];

  // Idle step length in samples at the wake rate
  always_comb begin
    // Nibble lookup; only the low four bits of the shifted word are kept
    wake_shift = 4'(`AWSC_RATE_SHIFTS >>
                    {s_q.ctrl_one[`AWSC_WAKE_RATE_LSB +: 3], 2'b00});
    // Slowest rate doubles the step, which leaves one sample per step
    if (wake_shift == `AWSC_SLOWEST_SHIFT) begin
      per_step = 10'(`AWSC_SLOW_BASE_TICKS >> wake_shift);
    end else begin
      per_step = 10'(`AWSC_STEP_BASE_TICKS >> wake_shift);
    end
  end

  // Read multiplexer; unmapped words read zero
  always_comb begin
    case (idx)
      `AWSC_IDX_INACT:    rd_mux = s_q.inact_dur;
      `AWSC_IDX_CTRL_ONE: rd_mux = s_q.ctrl_one;
      `AWSC_IDX_CTRL_TWO: rd_mux = s_q.ctrl_two;
      `AWSC_IDX_WAKE_CFG: rd_mux = s_q.wake_cfg;
      `AWSC_IDX_INT_CFG:  rd_mux = s_q.int_cfg;
      `AWSC_IDX_STATUS:   rd_mux = {6'h00, s_q.status};
      `AWSC_IDX_MASK:     rd_mux = {6'h00, s_q.mask};
      `AWSC_IDX_STATE:    rd_mux = {2'h0, s_q.hold, s_q.rate, s_q.mode};
      default:            rd_mux = 8'h00;
    endcase
  end

  // Next-state logic: bus, mode sequencer, FIFO gate, status
  always_comb begin
    s_d        = s_q;
    transition = 1'b0;
    s_d.ack    = req & ~s_q.ack;
    // Read data captured in the wait cycle, shown at the accepting edge
    if (req && !s_q.ack) begin
      s_d.rdata = rd_mux;
    end
    // Register writes, low byte lane only
    if (accept && AVS_WRITE && AVS_BYTEENABLE[0]) begin
      case (idx)
        `AWSC_IDX_INACT: begin
          s_d.inact_dur = AVS_WRITEDATA[7:0];
        end
        `AWSC_IDX_CTRL_ONE: begin
          // Rates only change in standby; active bit always
          // A rate change mid-run would leave the idle step length stale
          if (s_q.mode == AWSC_STANDBY) begin
            s_d.ctrl_one = AVS_WRITEDATA[7:0];
          end else begin
            s_d.ctrl_one[`AWSC_ACTIVE_BIT] = AVS_WRITEDATA[`AWSC_ACTIVE_BIT];
          end
        end
        `AWSC_IDX_CTRL_TWO: begin
          // Reset bit is self-clearing and always reads zero
          s_d.ctrl_two = AVS_WRITEDATA[7:0] & 8'hBF;
        end
        `AWSC_IDX_WAKE_CFG: begin
          s_d.wake_cfg = AVS_WRITEDATA[7:0];
        end
        `AWSC_IDX_INT_CFG: begin
          s_d.int_cfg = AVS_WRITEDATA[7:0];
        end
        `AWSC_IDX_MASK: begin
          s_d.mask = AVS_WRITEDATA[1:0];
        end
        default: begin
          // Read-only or unmapped: ignored
        end
      endcase
    end
    // Reading status clears it; sets below win over this clear
    // so an event in the clearing cycle is never lost
    if (accept && AVS_READ && idx == `AWSC_IDX_STATUS) begin
      s_d.status = 2'b00;
    end
    // Mode sequencer; sleep/wake and sample-ready never steer it
    case (s_q.mode)
      AWSC_STANDBY: begin
        if (active) begin
          s_d.mode     = AWSC_WAKE;
          s_d.sub_cnt  = '0;
          s_d.step_cnt = '0;
        end
      end
      AWSC_WAKE: begin
        if (!active) begin
          s_d.mode = AWSC_STANDBY;
        end else if (|src_restart) begin
          // Enabled activity delays the return to sleep
          s_d.sub_cnt  = '0;
          s_d.step_cnt = '0;
        end else if (odr_tick) begin
          if (auto_on && s_q.step_cnt >= s_q.inact_dur) begin
            s_d.mode   = AWSC_SLEEP;
            transition = 1'b1;
          end else if (10'(s_q.sub_cnt) + 10'h001 >= per_step) begin
            s_d.sub_cnt = '0;
            // Saturate so long idle cannot wrap
            if (s_q.step_cnt != 8'hFF) begin
              s_d.step_cnt = s_q.step_cnt + 8'h01;
            end
          end else begin
            s_d.sub_cnt = s_q.sub_cnt + 9'h001;
          end
        end
      end
      AWSC_SLEEP: begin
        // Leaving to standby is not a sleep transition, so no interrupt
        if (!active) begin
          s_d.mode = AWSC_STANDBY;
        end else if ((|src_wake) || !auto_on) begin
          // Selected events wake; auto sleep off forbids staying
          s_d.mode     = AWSC_WAKE;
          s_d.sub_cnt  = '0;
          s_d.step_cnt = '0;
          transition   = 1'b1;
        end
      end
      default: begin
        s_d.mode = AWSC_STANDBY;
      end
    endcase
    // Effective rate: sleep rate overrides the wake rate
    // Taken from the next mode so rate and mode change on the same edge
    if (s_d.mode == AWSC_SLEEP) begin
      s_d.rate = {1'b1, s_d.ctrl_one[`AWSC_SLEEP_RATE_LSB +: 2]};
    end else begin
      s_d.rate = s_d.ctrl_one[`AWSC_WAKE_RATE_LSB +: 3];
    end
    // FIFO hold: flush releases, a gated rate change sets; set wins
    if (FIFO_FLUSH) begin
      s_d.hold = 1'b0;
    end
    if (transition && s_q.wake_cfg[`AWSC_FIFO_GATE_BIT]) begin
      s_d.hold = 1'b1;
    end
    // Sticky status events
    // Refused samples are flagged so software knows data was dropped
    if (transition && s_q.int_cfg[`AWSC_SW_INT_BIT]) begin
      s_d.status[`AWSC_ST_TRANSITION] = 1'b1;
    end
    if (SAMPLE_VALID && s_q.hold) begin
      s_d.status[`AWSC_ST_REFUSED] = 1'b1;
    end
    // Software reset restores every default, bus handshake kept
    if (soft_clr) begin
      s_d     = S_RST;
      s_d.ack = 1'b0;
    end
  end

  // State register
  // Synchronous reset only; every reset value is a constant
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Bus answers
  assign AVS_WAITREQUEST = req & ~s_q.ack;
  assign AVS_READDATA    = {24'h00_0000, s_q.rdata};

  // Samples pass only while the gate is open
  // Combinational, so a sample refused in this cycle never reaches the FIFO
  assign SAMPLE_WRITE = SAMPLE_VALID & ~s_q.hold;
  assign FIFO_HOLD    = s_q.hold;

  // Detection blocks sample on this tick in wake and sleep alike
  assign SAMPLE_TICK = odr_tick & (s_q.mode != AWSC_STANDBY);
  assign RATE_CODE   = s_q.rate;
  assign MODE        = s_q.mode;

  // Level interrupt from unmasked sticky status
  // The mask gates the pin only; status bits stay set underneath
  assign IRQ = |(s_q.status & s_q.mask);

endmodule

// >>> verif/awsc_top_monitor.sv
`timescale 1ns/1ps
module awsc_top_monitor
  import awsc_pkg::*;
(
  // Clock and reset
  input wire logic        CORE_CLK,
  input wire logic        RST_N,
  // Register bus
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  // Events and FIFO side
  input wire logic        EVT_TRANSIENT,
  input wire logic        EVT_ORIENTATION,
  input wire logic        EVT_TAP,
  input wire logic        EVT_FREEFALL_MOTION,
  input wire logic        EVT_FIFO_GATE,
  input wire logic        SAMPLE_VALID,
  input wire logic        FIFO_FLUSH,
  input wire logic        SAMPLE_WRITE,
  input wire logic        FIFO_HOLD,
  // Rate and mode
  input wire logic        SAMPLE_TICK,
  input wire logic [2:0]  RATE_CODE,
  input wire logic [1:0]  MODE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  // Any motion event, the ones that may wake
  logic motion;
  assign motion = EVT_TRANSIENT | EVT_ORIENTATION | EVT_TAP | EVT_FREEFALL_MOTION;

  bus_wait_a: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus wait longer than one cycle");
  read_width_a: assert property (
    AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  sleep_tick_a: assert property (
    MODE == AWSC_SLEEP && $past(MODE) == AWSC_WAKE |-> $past(SAMPLE_TICK))
    else $error("sleep entered off a sample tick");
  sleep_rate_a: assert property (
    MODE == AWSC_SLEEP |-> RATE_CODE[2])
    else $error("sleep mode without sleep rate");
  // A write could clear auto sleep, so it is left out
  fifo_nowake_a: assert property (
    MODE == AWSC_SLEEP && EVT_FIFO_GATE && !motion && !AVS_WRITE |=> MODE != AWSC_WAKE)
    else $error("fifo activity woke the device");
  gate_write_a: assert property (
    SAMPLE_WRITE == (SAMPLE_VALID && !FIFO_HOLD))
    else $error("sample passed the fifo gate");
  hold_cause_a: assert property (
    $rose(FIFO_HOLD) |-> MODE != $past(MODE))
    else $error("hold set without rate change");
  flush_clear_a: assert property (
    FIFO_HOLD && FIFO_FLUSH |=> !FIFO_HOLD || MODE != $past(MODE))
    else $error("flush did not release hold");
  standby_quiet_a: assert property (
    MODE == AWSC_STANDBY |-> !SAMPLE_TICK)
    else $error("sample tick in standby");

  // Main scenarios reached
  cover property (MODE == AWSC_SLEEP ##1 MODE == AWSC_WAKE);
  cover property ($rose(FIFO_HOLD));
  cover property (AVS_READ && !AVS_WAITREQUEST);
  cover property (MODE == AWSC_SLEEP && EVT_FIFO_GATE && !AVS_WRITE);
endmodule

bind awsc_top awsc_top_monitor awsc_top_monitor_inst (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .EVT_TRANSIENT(EVT_TRANSIENT), .EVT_ORIENTATION(EVT_ORIENTATION), .EVT_TAP(EVT_TAP),
  .EVT_FREEFALL_MOTION(EVT_FREEFALL_MOTION), .EVT_FIFO_GATE(EVT_FIFO_GATE),
  .SAMPLE_VALID(SAMPLE_VALID), .FIFO_FLUSH(FIFO_FLUSH), .SAMPLE_WRITE(SAMPLE_WRITE),
  .FIFO_HOLD(FIFO_HOLD), .SAMPLE_TICK(SAMPLE_TICK), .RATE_CODE(RATE_CODE), .MODE(MODE));

// >>> verif/test_awsc_top.sv
`timescale 1ns/1ps
module test_awsc_top
  import awsc_pkg::*;
;
  // Clock, reset and bus master
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr  = 8'h00;
  logic        av_rd = 1'b0;
  logic        av_wr = 1'b0;
  logic [31:0] wdat  = 32'h0000_0000;
  logic [31:0] rdat;
  logic        wait_s;
  // Events (0 fifo, 1 ff/motion, 2 tap, 3 orientation, 4 transient)
  logic [4:0]  evt   = 5'h00;
  logic        vld   = 1'b0;
  logic        flush = 1'b0;
  // Observed outputs
  logic        swr;
  logic        hold;
  logic        tick;
  logic        irq;
  logic [2:0]  rate;
  logic [1:0]  mode;
  // Bookkeeping
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          n;
  int          e;
  int          p;
  logic [2:0]  r;
  logic [7:0]  q;
  logic [5:0]  ix [9] = '{6'h29, 6'h2A, 6'h2B, 6'h2C, 6'h2D, 6'h30, 6'h31, 6'h32, 6'h3F};

  // Small base divider keeps idle steps short
  awsc_top #(.BASE_CYCLES(4)) awsc_top_inst (
    .CORE_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(av_rd),
    .AVS_WRITE(av_wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'h1),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_s), .EVT_TRANSIENT(evt[4]),
    .EVT_ORIENTATION(evt[3]), .EVT_TAP(evt[2]), .EVT_FREEFALL_MOTION(evt[1]),
    .EVT_FIFO_GATE(evt[0]), .SAMPLE_VALID(vld), .FIFO_FLUSH(flush),
    .SAMPLE_WRITE(swr), .FIFO_HOLD(hold), .SAMPLE_TICK(tick), .RATE_CODE(rate),
    .MODE(mode), .IRQ(irq));

  // 100 MHz clock
  always #5 clk = ~clk;

  // Hang guard, well above the longest idle waits
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // Verdict and end of run
  task automatic give_verdict();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Value compare
  task automatic cmp(input logic [7:0] g, input logic [7:0] x);
    cmp_count++;
    if (g !== x) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, x);
    end
  endtask

  // One bus transfer; an edge passes first so strobes never toggle twice
  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d);
    @(posedge clk);
    addr <= {i, 2'b00};
    av_wr <= w;
    av_rd <= ~w;
    wdat <= {24'h00_0000, d};
    do @(posedge clk); while (wait_s !== 1'b0);
    q = rdat[7:0];
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
  endtask

  task automatic rd(input logic [5:0] i, input logic [7:0] x);
    bus(1'b0, i, 8'h00);
    cmp(q, x);
  endtask

  // One-cycle pulse, then look once outputs settle
  task automatic ev(input logic [4:0] m);
    @(posedge clk);
    evt <= m;
    @(posedge clk);
    evt <= 5'h00;
    @(negedge clk);
  endtask

  // Bounded wait for a mode
  task automatic wt(input logic [1:0] m);
    n = 0;
    while (mode !== m && n < 9000) begin
      @(posedge clk);
      n++;
    end
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 9; k++) rd(ix[k], 8'h00);
    wr(6'h3F, 8'hFF);
    rd(6'h3F, 8'h00);
    wr(6'h29, 8'hA5);
    rd(6'h29, 8'hA5);
    // Auto sleep off with zero idle time: must stay awake
    wr(6'h29, 8'h00);
    wr(6'h2A, 8'h01);
    repeat (300) @(posedge clk);
    cmp(8'(mode), 8'h01);
    // Four-cycle base tick at the fastest rate: ten samples in forty cycles
    n = 0;
    repeat (40) begin
      @(negedge clk);
      n += tick;
    end
    cmp(8'(n), 8'h0A);
    wr(6'h2C, 8'hC0);
    wr(6'h2D, 8'hC4);
    // Every sleep rate, transition interrupt, gate, wake sources
    for (int s = 0; s < 4; s++) begin
      wr(6'h2A, 8'h00);
      wr(6'h2A, {s[1:0], 6'h01});
      wr(6'h2B, 8'h04);
      wt(AWSC_SLEEP);
      cmp(8'(rate), {6'h01, s[1:0]});
      cmp(8'(hold), 8'h01);
      @(posedge clk);
      vld <= 1'b1;
      @(negedge clk);
      cmp(8'(swr), 8'h00);
      @(posedge clk);
      vld <= 1'b0;
      wr(6'h31, 8'h00);
      @(negedge clk);
      cmp(8'(irq), 8'h00);
      wr(6'h31, 8'h01);
      @(negedge clk);
      cmp(8'(irq), 8'h01);
      rd(6'h30, 8'h03);
      rd(6'h30, 8'h00);
      @(negedge clk);
      cmp(8'(irq), 8'h00);
      @(posedge clk);
      flush <= 1'b1;
      @(posedge clk);
      flush <= 1'b0;
      @(negedge clk);
      cmp(8'(hold), 8'h00);
      ev(5'h01);
      cmp(8'(mode), 8'h02);
      ev(5'h05);
      cmp(8'(mode), 8'h02);
      ev(5'h10);
      cmp(8'(mode), 8'h01);
      wr(6'h2B, 8'h00);
    end
    // Idle time at fast and slowest rate, and restart by fifo activity
    wr(6'h29, 8'h02);
    for (int c = 0; c < 3; c++) begin
      r = (c == 2) ? 3'h7 : 3'h0;
      wr(6'h2A, 8'h00);
      wr(6'h2B, 8'h04);
      wr(6'h2A, {2'b00, r, 3'h1});
      n = 0;
      while (mode !== AWSC_SLEEP && n < 9000) begin
        @(posedge clk);
        n++;
        evt <= (c == 1 && n == 1000) ? 5'h01 : 5'h00;
      end
      e = (c == 1 ? 1000 : 0) + (r == 3'h7 ? 4096 : 2048);
      p = (r == 3'h7) ? 2048 : 4;
      cmp(8'(n > e - p && n <= e + p + 8), 8'h01);
      wr(6'h2B, 8'h00);
    end
    // Software reset restores defaults
    wr(6'h2B, 8'h40);
    rd(6'h29, 8'h00);
    rd(6'h2B, 8'h00);
    cmp(8'(mode), 8'h00);
    give_verdict();
  end
endmodule
